// *** rtl/mlx_exec.v ***
// Execution sequencer for byte transfers between working registers and memory spaces
`timescale 1ns/1ps
`include "mlx_map.vh"
module mlx_exec #(
    parameter MASK_ROM = 1'b0
) (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        instr_valid,
    input  wire [7:0]  instr_opcode,
    input  wire [7:0]  instr_byte1,
    input  wire [7:0]  instr_byte2,
    input  wire [7:0]  instr_byte3,
    input  wire [7:0]  flags_in,
    input  wire [7:0]  reg_rd_data,
    input  wire [7:0]  mem_rd_data,
    output reg  [3:0]  reg_rd_index,
    output reg         reg_wr_en,
    output reg  [3:0]  reg_wr_index,
    output reg  [7:0]  reg_wr_data,
    output reg         mem_rd_en,
    output reg         mem_wr_en,
    output reg         mem_space_data,
    output reg  [15:0] mem_addr,
    output reg  [7:0]  mem_wr_data,
    output reg  [7:0]  flags_out,
    output reg         busy,
    output reg         done,
    output reg         illegal,
    output reg  [2:0]  instr_len
);
    // =========================================================================
    // States
    localparam ST_IDLE = 3'd0;
    localparam ST_PHI  = 3'd1;
    localparam ST_PLO  = 3'd2;
    localparam ST_OPER = 3'd3;
    localparam ST_MEM  = 3'd4;
    localparam ST_PTRH = 3'd5;
    localparam ST_WAIT = 3'd6;

    reg [2:0]  state_r;
    reg [4:0]  cyc_r;
    reg [7:0]  op_r;
    reg [3:0]  wreg_r;
    reg [3:0]  pair_r;
    reg [15:0] off_r;
    reg [15:0] da_r;
    reg        direct_r;
    reg [7:0]  phi_r;
    reg [7:0]  plo_r;
    reg [7:0]  src_r;
    reg [15:0] newptr_r;

    wire [15:0] ptr;
    wire [15:0] acc_addr;
    wire [15:0] ptr_inc;
    wire [15:0] ptr_dec;

    mlx_addr_unit u_addr (
        .pair_hi        (phi_r),
        .pair_lo        (plo_r),
        .offset         (off_r),
        .use_direct     (direct_r),
        .direct_address (da_r),
        .pointer        (ptr),
        .access_addr    (acc_addr),
        .pointer_inc    (ptr_inc),
        .pointer_dec    (ptr_dec)
    );

    // =========================================================================
    // Decode of the fetched instruction
    wire [3:0] f_hi = instr_byte1[`MLX_FLD_HI_MSB:`MLX_FLD_HI_LSB];
    wire [3:0] f_lo = instr_byte1[`MLX_FLD_LO_MSB:`MLX_FLD_LO_LSB];
    reg        is_load;
    reg        is_store;
    reg        is_long;
    reg        is_short;
    reg [4:0]  d_cyc;
    reg [2:0]  d_len;

    // =========================================================================
    // Opcode table: direction, offset form, cycle budget and length
    always @* begin
        case (instr_opcode)
            `MLX_OP_LD_PAIR: begin
                is_load  = 1'b1;
                is_store = 1'b0;
                is_long  = 1'b0;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_PLAIN;
                d_len    = `MLX_LEN_PLAIN;
            end
            `MLX_OP_ST_PAIR: begin
                is_load  = 1'b0;
                is_store = 1'b1;
                is_long  = 1'b0;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_PLAIN;
                d_len    = `MLX_LEN_PLAIN;
            end
            `MLX_OP_LD_SHORT: begin
                is_load  = 1'b1;
                is_store = 1'b0;
                is_long  = 1'b0;
                is_short = 1'b1;
                d_cyc    = `MLX_CYC_SHORT;
                d_len    = `MLX_LEN_SHORT;
            end
            `MLX_OP_ST_SHORT: begin
                is_load  = 1'b0;
                is_store = 1'b1;
                is_long  = 1'b0;
                is_short = 1'b1;
                d_cyc    = `MLX_CYC_SHORT;
                d_len    = `MLX_LEN_SHORT;
            end
            `MLX_OP_LD_LONG: begin
                is_load  = 1'b1;
                is_store = 1'b0;
                is_long  = 1'b1;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_LONG;
                d_len    = `MLX_LEN_LONG;
            end
            `MLX_OP_ST_LONG: begin
                is_load  = 1'b0;
                is_store = 1'b1;
                is_long  = 1'b1;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_LONG;
                d_len    = `MLX_LEN_LONG;
            end
            `MLX_OP_LD_PDEC: begin
                is_load  = 1'b1;
                is_store = 1'b0;
                is_long  = 1'b0;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_PLAIN;
                d_len    = `MLX_LEN_PLAIN;
            end
            `MLX_OP_LD_PINC: begin
                is_load  = 1'b1;
                is_store = 1'b0;
                is_long  = 1'b0;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_PLAIN;
                d_len    = `MLX_LEN_PLAIN;
            end
            `MLX_OP_ST_PREDEC: begin
                is_load  = 1'b0;
                is_store = 1'b1;
                is_long  = 1'b0;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_PREDEC;
                d_len    = `MLX_LEN_PLAIN;
            end
            default: begin
                is_load  = 1'b0;
                is_store = 1'b0;
                is_long  = 1'b0;
                is_short = 1'b0;
                d_cyc    = `MLX_CYC_PLAIN;
                d_len    = `MLX_LEN_PLAIN;
            end
        endcase
    end

    // Register in high field, pair or direct selector in low
    wire [3:0] d_wreg = f_hi;
    wire [3:0] d_pair = f_lo;
    wire d_direct = is_long && (d_pair[3:1] == 3'b000);
    wire d_space  = d_direct ? (d_pair == `MLX_DIRECT_DATA) : d_pair[0];
    wire d_refuse = is_store && !d_space && MASK_ROM;

    // =========================================================================
    // Operation held for the running instruction
    wire op_is_load  = (op_r == `MLX_OP_LD_PAIR) || (op_r == `MLX_OP_LD_SHORT) ||
                       (op_r == `MLX_OP_LD_LONG) || (op_r == `MLX_OP_LD_PDEC) ||
                       (op_r == `MLX_OP_LD_PINC);
    wire op_predec   = (op_r == `MLX_OP_ST_PREDEC);
    wire op_pointer  = (op_r == `MLX_OP_LD_PDEC) || (op_r == `MLX_OP_LD_PINC) || op_predec;
    wire [15:0] eff_addr = op_predec ? ptr_dec : acc_addr;

    // =========================================================================
    // Sequencer
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r        <= ST_IDLE;
            cyc_r          <= 5'h00;
            op_r           <= 8'h00;
            wreg_r         <= 4'h0;
            pair_r         <= 4'h0;
            off_r          <= 16'h0000;
            da_r           <= 16'h0000;
            direct_r       <= 1'b0;
            phi_r          <= 8'h00;
            plo_r          <= 8'h00;
            src_r          <= 8'h00;
            newptr_r       <= 16'h0000;
            reg_rd_index   <= 4'h0;
            reg_wr_en      <= 1'b0;
            reg_wr_index   <= 4'h0;
            reg_wr_data    <= 8'h00;
            mem_rd_en      <= 1'b0;
            mem_wr_en      <= 1'b0;
            mem_space_data <= 1'b0;
            mem_addr       <= 16'h0000;
            mem_wr_data    <= 8'h00;
            flags_out      <= 8'h00;
            busy           <= 1'b0;
            done           <= 1'b0;
            illegal        <= 1'b0;
            instr_len      <= 3'h0;
        end else begin
            reg_wr_en <= 1'b0;
            mem_rd_en <= 1'b0;
            mem_wr_en <= 1'b0;
            done      <= 1'b0;
            illegal   <= 1'b0;
            flags_out <= flags_in;
            if (state_r != ST_IDLE)
                cyc_r <= cyc_r - 5'h01;
            case (state_r)
                ST_IDLE: begin
                    busy <= 1'b0;
                    if (instr_valid && (is_load || is_store)) begin
                        if (d_refuse) begin
                            illegal <= 1'b1;
                            done    <= 1'b1;
                        end else begin
                            op_r           <= instr_opcode;
                            wreg_r         <= d_wreg;
                            pair_r         <= d_pair;
                            direct_r       <= d_direct;
                            mem_space_data <= d_space;
                            da_r           <= {instr_byte3, instr_byte2};
                            off_r          <= is_long ? {instr_byte3, instr_byte2} :
                                              (is_short ? {8'h00, instr_byte2} : 16'h0000);
                            instr_len      <= d_len;
                            cyc_r          <= d_cyc - 5'h01;
                            busy           <= 1'b1;
                            reg_rd_index   <= {d_pair[3:1], 1'b0};
                            state_r        <= ST_PHI;
                        end
                    end
                end
                ST_PHI: begin
                    phi_r        <= reg_rd_data;
                    reg_rd_index <= {pair_r[3:1], 1'b1};
                    state_r      <= ST_PLO;
                end
                ST_PLO: begin
                    plo_r        <= reg_rd_data;
                    reg_rd_index <= wreg_r;
                    state_r      <= ST_OPER;
                end
                ST_OPER: begin
                    src_r   <= reg_rd_data;
                    state_r <= ST_MEM;
                end
                ST_MEM: begin
                    mem_addr <= eff_addr;
                    if (op_is_load) begin
                        mem_rd_en <= 1'b1;
                    end else begin
                        mem_wr_en   <= 1'b1;
                        mem_wr_data <= src_r;
                    end
                    if (op_r == `MLX_OP_LD_PDEC)
                        newptr_r <= ptr_dec;
                    else if (op_r == `MLX_OP_LD_PINC)
                        newptr_r <= ptr_inc;
                    else
                        newptr_r <= ptr_dec;
                    state_r <= ST_PTRH;
                end
                ST_PTRH: begin
                    if (op_is_load) begin
                        reg_wr_en    <= 1'b1;
                        reg_wr_index <= wreg_r;
                        reg_wr_data  <= mem_rd_data;
                    end
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    // Pointer update after the data move, only for pointer forms
                    if (op_pointer && (cyc_r == 5'h02)) begin
                        reg_wr_en    <= 1'b1;
                        reg_wr_index <= {pair_r[3:1], 1'b0};
                        reg_wr_data  <= newptr_r[15:8];
                    end else if (op_pointer && (cyc_r == 5'h01)) begin
                        reg_wr_en    <= 1'b1;
                        reg_wr_index <= {pair_r[3:1], 1'b1};
                        reg_wr_data  <= newptr_r[7:0];
                    end
                    if (cyc_r == 5'h00) begin
                        done    <= 1'b1;
                        busy    <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // mlx_exec

// *** rtl/mlx_map.vh ***
// Constants for the memory-space load/store execution block
// Contract
// - C3 loads byte at pair address into register; D3 stores; 2 bytes, 10 cycles
// - Even pair designator selects program memory, odd selects data memory
// - Source operand is never changed except the auto pointer update
// - No instruction of this group changes any flag bit
// - E7/F7 add one-byte offset from third byte; 3 bytes, 12 cycles
// - A7/B7 add two-byte offset, low byte first; 4 bytes, 14 cycles
// - Long forms with pair field zero-one mean direct addressing, not index
// - Long field 0000 is program memory, 0001 data memory, direct address low first
// - Even register gives high address byte, odd register gives low byte
// - Mask-programmed devices refuse stores into program memory
// - E2 loads then decrements the 16-bit pointer; 2 bytes, 10 cycles
// - E3 loads then increments the 16-bit pointer; 2 bytes, 10 cycles
// - F2 decrements pointer first, then stores at new address; 2 bytes, 14 cycles
`ifndef MLX_MAP_VH
`define MLX_MAP_VH
`define MLX_OP_LD_PAIR    8'hc3
`define MLX_OP_ST_PAIR    8'hd3
`define MLX_OP_LD_SHORT   8'he7
`define MLX_OP_ST_SHORT   8'hf7
`define MLX_OP_LD_LONG    8'ha7
`define MLX_OP_ST_LONG    8'hb7
`define MLX_OP_LD_PDEC    8'he2
`define MLX_OP_LD_PINC    8'he3
`define MLX_OP_ST_PREDEC  8'hf2
`define MLX_CYC_PLAIN     5'h0a
`define MLX_CYC_SHORT     5'h0c
`define MLX_CYC_LONG      5'h0e
`define MLX_CYC_PREDEC    5'h0e
`define MLX_LEN_PLAIN     3'h2
`define MLX_LEN_SHORT     3'h3
`define MLX_LEN_LONG      3'h4
`define MLX_FLD_HI_MSB    7
`define MLX_FLD_HI_LSB    4
`define MLX_FLD_LO_MSB    3
`define MLX_FLD_LO_LSB    0
`define MLX_DIRECT_PROG   4'h0
`define MLX_DIRECT_DATA   4'h1
`endif

// *** rtl/mlx_addr_unit.v ***
// 16-bit address former for pointer, offset and step arithmetic
`timescale 1ns/1ps
module mlx_addr_unit (
    input  wire [7:0]  pair_hi,
    input  wire [7:0]  pair_lo,
    input  wire [15:0] offset,
    input  wire        use_direct,
    input  wire [15:0] direct_address,
    output wire [15:0] pointer,
    output wire [15:0] access_addr,
    output wire [15:0] pointer_inc,
    output wire [15:0] pointer_dec
);
    assign pointer     = {pair_hi, pair_lo};
    assign access_addr = use_direct ? direct_address : pointer + offset;
    assign pointer_inc = pointer + 16'h0001;
    assign pointer_dec = pointer - 16'h0001;
endmodule // mlx_addr_unit

// *** testbench/mlx_mem_model.sv ***
// Working register file and program/data memory arrays
`timescale 1ns/1ps
module mlx_mem_model (
    input  wire       sys_clk,
    input  wire [3:0] reg_rd_index,
    output wire [7:0] reg_rd_data,
    input  wire       reg_wr_en,
    input  wire [3:0] reg_wr_index,
    input  wire [7:0] reg_wr_data,
    input  wire       mem_rd_en,
    input  wire       mem_wr_en,
    input  wire       mem_space_data,
    input  wire [15:0] mem_addr,
    input  wire [7:0] mem_wr_data,
    output wire [7:0] mem_rd_data
);
    logic [7:0] regs [0:15];
    logic [7:0] prog [0:65535];
    logic [7:0] data [0:65535];
    wire  [7:0] mem_cell = mem_space_data ? data[mem_addr] : prog[mem_addr];
    assign reg_rd_data = regs[reg_rd_index];
    // Read answers in the strobe cycle; idle bus shows the inverse so stale data never matches
    assign mem_rd_data = mem_rd_en ? mem_cell : ~mem_cell;
    always @(posedge sys_clk) begin
        if (reg_wr_en) regs[reg_wr_index] <= reg_wr_data;
        // Space chosen by the level at access time
        if (mem_wr_en && mem_space_data) data[mem_addr] <= mem_wr_data;
        if (mem_wr_en && !mem_space_data) prog[mem_addr] <= mem_wr_data;
    end
endmodule // mlx_mem_model

// *** testbench/mlx_exec_sva.sv ***
// Assertion checker for the execution sequencer ports
`timescale 1ns/1ps
module mlx_exec_sva #(
    parameter MASK_ROM = 1'b0
) (
    input wire       sys_clk,
    input wire       reset_n,
    input wire       instr_valid,
    input wire [7:0] instr_opcode,
    input wire [7:0] instr_byte1,
    input wire [7:0] flags_in,
    input wire [7:0] flags_out,
    input wire       reg_wr_en,
    input wire       mem_rd_en,
    input wire       mem_wr_en,
    input wire       mem_space_data,
    input wire       busy,
    input wire       done,
    input wire       illegal,
    input wire [2:0] instr_len
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire [7:0] op    = instr_opcode;
    wire plain       = op == 8'hc3 || op == 8'hd3 || op == 8'he2 || op == 8'he3;
    wire shrt        = op == 8'he7 || op == 8'hf7;
    wire lng         = op == 8'ha7 || op == 8'hb7 || op == 8'hf2;
    wire st          = op == 8'hd3 || op == 8'hf7 || op == 8'hb7 || op == 8'hf2;
    wire take        = !busy && instr_valid && (plain || shrt || lng);
    wire refuse      = st && !instr_byte1[0] && MASK_ROM;
    reg        space_r;
    reg  [2:0] len_r;
    reg        pst_r;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            space_r <= 1'b0;
            len_r   <= 3'h0;
            pst_r   <= 1'b0;
        end else if (take) begin
            space_r <= instr_byte1[0];
            len_r   <= (plain || op == 8'hf2) ? 3'h2 : (shrt ? 3'h3 : 3'h4);
            pst_r   <= st && op != 8'hf2;
        end
    end
    sequence s_go(f);
        take && !refuse && f;
    endsequence
    AST_LAT_PLAIN: assert property (s_go(plain) |-> ##11 done) else $error("plain latency");
    AST_LAT_SHORT: assert property (s_go(shrt) |-> ##13 done) else $error("short latency");
    AST_LAT_LONG: assert property (s_go(lng) |-> ##15 done) else $error("long latency");
    AST_SPACE: assert property (mem_rd_en || mem_wr_en |-> mem_space_data == space_r) else $error("space");
    AST_SRC: assert property (reg_wr_en |-> !pst_r) else $error("store wrote register");
    AST_FLAGS: assert property ($past(reset_n) |-> flags_out == $past(flags_in)) else $error("flags");
    AST_ROM: assert property (mem_wr_en |-> !MASK_ROM || mem_space_data) else $error("rom write");
    AST_REFUSE: assert property (take && refuse |=> (illegal && done)) else $error("refuse");
    AST_LEN: assert property (done && !illegal |-> instr_len == len_r) else $error("length");
    AST_DONE_ONE: assert property (done |=> !done) else $error("done width");
endmodule // mlx_exec_sva
bind mlx_exec mlx_exec_sva #(.MASK_ROM(MASK_ROM)) u_sva (.*);

// *** testbench/mlx_exec_bench.sv ***
// Self-checking bench for the execution sequencer
`timescale 1ns/1ps
module mlx_exec_bench;
    reg         sys_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         instr_valid = 1'b0;
    reg  [7:0]  instr_opcode = 8'h00, instr_byte1 = 8'h00, instr_byte2 = 8'h00, instr_byte3 = 8'h00;
    reg  [7:0]  flags_in = 8'h5a;
    wire [7:0]  reg_rd_data, mem_rd_data, reg_wr_data, mem_wr_data, flags_out;
    wire [3:0]  reg_rd_index, reg_wr_index;
    wire        reg_wr_en, mem_rd_en, mem_wr_en, mem_space_data, busy, done, illegal;
    wire [15:0] mem_addr;
    wire [2:0]  instr_len;
    integer     fail_count = 0;
    integer     checks = 0;
    wire        rom_mem_wr_en, rom_mem_space_data, rom_done, rom_illegal;
    integer     rom_refused = 0;
    integer     bad_events = 0;
    always #5 sys_clk = ~sys_clk;
    mlx_exec dut (.*);
    mlx_mem_model mem (.*);
    // Mask-ROM variant fed the same instructions, watched for refused program stores
    mlx_exec #(.MASK_ROM(1'b1)) dut_rom (
        .sys_clk        (sys_clk),
        .reset_n        (reset_n),
        .instr_valid    (instr_valid),
        .instr_opcode   (instr_opcode),
        .instr_byte1    (instr_byte1),
        .instr_byte2    (instr_byte2),
        .instr_byte3    (instr_byte3),
        .flags_in       (flags_in),
        .reg_rd_data    (reg_rd_data),
        .mem_rd_data    (mem_rd_data),
        .reg_rd_index   (),
        .reg_wr_en      (),
        .reg_wr_index   (),
        .reg_wr_data    (),
        .mem_rd_en      (),
        .mem_wr_en      (rom_mem_wr_en),
        .mem_space_data (rom_mem_space_data),
        .mem_addr       (),
        .mem_wr_data    (),
        .flags_out      (),
        .busy           (),
        .done           (rom_done),
        .illegal        (rom_illegal),
        .instr_len      ()
    );
    always @(posedge sys_clk) begin
        if (rom_illegal && rom_done) rom_refused <= rom_refused + 1;
        if (illegal || (rom_mem_wr_en && !rom_mem_space_data)) bad_events <= bad_events + 1;
    end
    task end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task exec(input [7:0] op, input [7:0] b1, input [7:0] b2, input [7:0] b3, input [4:0] n);
        integer k;
        k = 0;
        @(posedge sys_clk);
        instr_opcode <= op;
        instr_byte1 <= b1;
        instr_byte2 <= b2;
        instr_byte3 <= b3;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        do begin
            @(posedge sys_clk);
            #1 k = k + 1;
        end while (done !== 1'b1 && k < 40);
        if (done !== 1'b1) begin
            fail_count = fail_count + 1;
            end_of_test;
        end else begin
            chk(k, n);
        end
    endtask
    task t_plain;
        mem.regs[0] = 8'h11; mem.regs[2] = 8'h01; mem.regs[3] = 8'h04;
        mem.prog[16'h0104] = 8'h1a; mem.data[16'h0104] = 8'h2a;
        exec(8'hc3, 8'h02, 8'h00, 8'h00, 5'd10);
        chk(mem.regs[0], 8'h1a);
        exec(8'hc3, 8'h13, 8'h00, 8'h00, 5'd10);
        chk(mem.regs[1], 8'h2a);
        exec(8'hd3, 8'h03, 8'h00, 8'h00, 5'd10);
        chk(mem.data[16'h0104], 8'h1a);
        exec(8'hd3, 8'h12, 8'h00, 8'h00, 5'd10);
        chk(mem.prog[16'h0104], 8'h2a);
        chk({mem.regs[2], mem.regs[3]}, 16'h0104);
        chk(mem.regs[1], 8'h2a);
        chk(rom_refused, 16'h0001);
        chk(instr_len, 3'h2);
    endtask
    task t_indexed;
        mem.prog[16'h0105] = 8'h6d; mem.prog[16'h1104] = 8'h88; mem.data[16'h1104] = 8'h98;
        mem.prog[16'h0103] = 8'h4f;
        exec(8'he7, 8'h02, 8'h01, 8'h00, 5'd12);
        chk(mem.regs[0], 8'h6d);
        exec(8'hf7, 8'h13, 8'hff, 8'h00, 5'd12);
        chk(mem.data[16'h0203], 8'h2a);
        exec(8'ha7, 8'h02, 8'h00, 8'h10, 5'd14);
        chk(mem.regs[0], 8'h88);
        exec(8'ha7, 8'h02, 8'hff, 8'hff, 5'd14);
        chk(mem.regs[0], 8'h4f);
        exec(8'ha7, 8'h10, 8'h04, 8'h11, 5'd14);
        chk(mem.regs[1], 8'h88);
        exec(8'ha7, 8'h11, 8'h04, 8'h11, 5'd14);
        chk(mem.regs[1], 8'h98);
        exec(8'hb7, 8'h01, 8'h05, 8'h11, 5'd14);
        chk(mem.data[16'h1105], 8'h4f);
        chk(instr_len, 3'h4);
        chk(flags_out, 8'ha5);
    endtask
    task t_pointer;
        mem.regs[6] = 8'h10; mem.regs[7] = 8'h33; mem.prog[16'h1033] = 8'hcd; mem.data[16'h1032] = 8'hdd;
        exec(8'he2, 8'h86, 8'h00, 8'h00, 5'd10);
        chk({mem.regs[6], mem.regs[7]}, 16'h1032);
        chk(mem.regs[8], 8'hcd);
        exec(8'he3, 8'h87, 8'h00, 8'h00, 5'd10);
        chk({mem.regs[6], mem.regs[7]}, 16'h1033);
        chk(mem.regs[8], 8'hdd);
        mem.regs[7] = 8'hff; mem.prog[16'h10ff] = 8'h3c;
        exec(8'he3, 8'h86, 8'h00, 8'h00, 5'd10);
        chk({mem.regs[6], mem.regs[7]}, 16'h1100);
        chk(mem.regs[8], 8'h3c);
        mem.regs[0] = 8'h77; mem.regs[6] = 8'h30; mem.regs[7] = 8'h00;
        exec(8'hf2, 8'h06, 8'h00, 8'h00, 5'd14);
        chk({mem.regs[6], mem.regs[7]}, 16'h2fff);
        chk(mem.prog[16'h2fff], 8'h77);
        chk(flags_out, 8'h5a);
        chk(rom_refused, 16'h0002);
        chk(bad_events, 16'h0000);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        chk(busy, 1'b0);
        reset_n <= 1'b1;
        t_plain;
        @(posedge sys_clk);
        flags_in <= 8'ha5;
        t_indexed;
        @(posedge sys_clk);
        flags_in <= 8'h5a;
        t_pointer;
        end_of_test;
    end
endmodule // mlx_exec_bench
